// ===== common/meter_pkg.sv
// Shared types and constants for the remote settings and event-status block.
// Assumes an upstream message parser that hands over one decoded command per
// cycle and an upstream formatter that turns answer codes into text.
package meter_pkg;

  // ********************************************************************
  // Command codes delivered by the message parser
  // ********************************************************************
  typedef enum logic [4:0] {
    CMD_NONE      = 5'b00000,
    CMD_AUX_WR    = 5'b00001,
    CMD_AUX_RD    = 5'b00010,
    CMD_TERM_WR   = 5'b00011,
    CMD_TERM_RD   = 5'b00100,
    CMD_EDGE_WR   = 5'b00101,
    CMD_EDGE_RD   = 5'b00110,
    CMD_MODE_WR   = 5'b00111,
    CMD_MODE_RD   = 5'b01000,
    CMD_LEVEL_WR  = 5'b01001,
    CMD_LEVEL_RD  = 5'b01010,
    CMD_SLICE_RD  = 5'b01011,
    CMD_TC_WR     = 5'b01100,
    CMD_TC_RD     = 5'b01101,
    CMD_BAD_RD    = 5'b01110,
    CMD_FLAGS_RD  = 5'b01111,
    CMD_ENA_WR    = 5'b10000,
    CMD_ENA_RD    = 5'b10001,
    CMD_CLEAR     = 5'b10010,
    CMD_STORE     = 5'b10011,
    CMD_RECALL    = 5'b10100,
    CMD_POLL      = 5'b10101
  } cmd_code_type;

  // ********************************************************************
  // Setting encodings
  // ********************************************************************
  typedef enum logic {
    TERM_50 = 1'b0,
    TERM_1M = 1'b1
  } term_type;

  typedef enum logic [1:0] {
    EDGE_POS    = 2'b00,
    EDGE_NEG    = 2'b01,
    EDGE_EITHER = 2'b10
  } edge_type;

  typedef enum logic [1:0] {
    BAL_AUTO   = 2'b00,
    BAL_OFFSET = 2'b01,
    BAL_MANUAL = 2'b10
  } bal_mode_type;

  // Time constant: 0.03 s, 0.1 s, 0.3 s, 1 s.
  typedef enum logic [1:0] {
    TC_30MS  = 2'b00,
    TC_100MS = 2'b01,
    TC_300MS = 2'b10,
    TC_1S    = 2'b11
  } time_const_type;

  // ********************************************************************
  // Carriers
  // ********************************************************************
  typedef struct packed {
    logic         valid;
    cmd_code_type code;
    logic [15:0]  data;
    logic         decodeErr;
  } command_type;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } response_type;

  typedef struct packed {
    logic [3:0]     auxNibble;
    term_type       term;
    edge_type       edgeSel;
    bal_mode_type   balMode;
    logic [11:0]    offsetLevel;
    logic [11:0]    sliceLevel;
    time_const_type timeConst;
  } settings_type;

  // ********************************************************************
  // Field positions, limits and reset values
  // ********************************************************************
  localparam int IN_RANGE_BIT  = 0;
  localparam int BAD_INPUT_BIT = 1;
  localparam int EXEC_ERR_BIT  = 4;
  localparam int CMD_ERR_BIT   = 5;
  localparam int SUMMARY_BIT   = 5;
  localparam int SERVICE_BIT   = 6;

  localparam logic [7:0]  USED_FLAG_MASK = 8'h33;
  localparam logic [7:0]  FLAGS_RESET    = 8'h00;
  localparam logic [15:0] AUX_MAX        = 16'h000f;
  localparam logic [15:0] BYTE_MAX       = 16'h00ff;
  localparam logic [15:0] SLOT_FIRST     = 16'h0001;
  localparam logic [15:0] SLOT_LAST      = 16'h0004;
  localparam logic signed [15:0] LEVEL_MIN = 16'shf800;
  localparam logic signed [15:0] LEVEL_MAX = 16'sh07ff;
  localparam logic [11:0] LEVEL_RESET    = 12'h000;
  localparam logic [3:0]  AUX_RESET      = 4'h0;
  localparam int          SETUP_SLOTS    = 4;

endpackage

// ===== src/setup_memory.sv
// Small setup memory holding saved instrument settings, one word per slot.
// Assumes one clock; read data appear from a register one cycle after rdEn.
`timescale 1ns/1ns
`default_nettype none

module setup_memory #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  input  wire logic                     wrEn,
  input  wire logic                     rdEn,
  input  wire logic [$clog2(DEPTH)-1:0] addr,
  input  wire logic [WIDTH-1:0]         wrData,
  output logic      [WIDTH-1:0]         rdData
);

  logic [WIDTH-1:0] store [DEPTH];

  // ********************************************************************
  // Storage
  // ********************************************************************

  // Contents are not reset; a recall of an unwritten slot is undefined.
  always_ff @(posedge ref_clk) begin
    if (wrEn) begin
      store[addr] <= wrData;
    end
  end

  // Read data come from a register so the memory maps onto block RAM.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdData <= '0;
    end else if (rdEn) begin
      rdData <= store[addr];
    end
  end

endmodule

`default_nettype wire

// ===== src/meter_remote_settings_status.sv
// Remote settings and event-status logic of the measuring instrument.
// Assumes a parser that delivers decoded commands, and analogue-side
// status levels synchronous to ref_clk.
//
// Contract
// - Drive written value onto aux output nibble.
// - Nibble query returns the driven value.
// - Aux nibble saved and restored with settings.
// - Hold termination setting, 50 or 1M.
// - Hold trigger edge setting and apply it.
// - Hold three-state balance mode, report on query.
// - Accept level -2048..2047, store twelve bits.
// - Level writes ignored in automatic mode.
// - Level goes to offset or slice per mode.
// - Local mode keeps level until panel moves.
// - Slicer query returns reference level always.
// - Hold one of four time constants.
// - Bad-input query returns one when unmeasurable.
// - Decode errors set flag bit five.
// - Execution errors set flag bit four.
// - Missing signal or bad clock sets bit one.
// - Measured value at or below limit sets bit zero.
// - Flags and enables share one bit layout.
// - Flag query returns contents; clear empties flags.
// - Summary bit is OR of enabled flags.
// - Serial poll clears the service request bit.
`timescale 1ns/1ns
`default_nettype none

module meter_remote_settings_status
  import meter_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire command_type   cmd,
  output logic               cmdReady,
  output response_type       resp,
  input  wire logic          remoteMode,
  input  wire logic          panelLevelMoved,
  input  wire logic [11:0]   panelLevel,
  input  wire logic [11:0]   sliceRef,
  input  wire logic          noSignal,
  input  wire logic          clockOutOfRange,
  input  wire logic          inRange,
  input  wire logic          rfIn,
  output logic               rfTrig,
  output logic [3:0]         auxOutputNibble,
  output settings_type       settings,
  output logic [7:0]         statusByte
);

  localparam int SLOT_W = $clog2(SETUP_SLOTS);
  localparam int SET_W  = $bits(settings_type);

  settings_type      settings_q;
  logic [7:0]        flags_q;
  logic [7:0]        flagEna_q;
  logic              service_q;
  logic              summaryPrev_q;
  response_type      resp_q;
  logic              rfPrev_q;
  logic              rfTrig_q;
  logic              recallLoad_q;
  logic [SLOT_W-1:0] slot;
  logic [SET_W-1:0]  memRead;
  logic              take;
  logic              dataOk;
  logic              cmdErr;
  logic              execErr;
  logic              summary;
  logic              badInput;
  logic [7:0]        flagEvents;

  // ********************************************************************
  // Elaboration checks
  // ********************************************************************

  // The slot decode assumes exactly the four documented setup slots.
  if (SETUP_SLOTS != 4) begin : gSlotCheck
    $error("setup memory must have four slots");
  end

  // ********************************************************************
  // Decode helpers
  // ********************************************************************

  // Range check of a write's data; reads and commands without data pass.
  function automatic logic inBounds(input cmd_code_type code,
                                    input logic [15:0] data);
    logic ok;
    ok = 1'b1;
    case (code)
      CMD_AUX_WR:   ok = (data <= AUX_MAX);
      CMD_TERM_WR:  ok = (data <= 16'h0001);
      CMD_EDGE_WR:  ok = (data <= 16'h0002);
      CMD_MODE_WR:  ok = (data <= 16'h0002);
      CMD_LEVEL_WR: ok = ($signed(data) >= LEVEL_MIN) &&
                         ($signed(data) <= LEVEL_MAX);
      CMD_TC_WR:    ok = (data <= 16'h0003);
      CMD_ENA_WR:   ok = (data <= BYTE_MAX);
      CMD_STORE,
      CMD_RECALL:   ok = (data >= SLOT_FIRST) && (data <= SLOT_LAST);
      default:      ok = 1'b1;
    endcase
    return ok;
  endfunction

  // Codes this block serves; anything else is an unsupported message.
  function automatic logic supported(input cmd_code_type code);
    logic ok;
    ok = 1'b0;
    case (code)
      CMD_NONE: ok = 1'b0;
      CMD_AUX_WR, CMD_AUX_RD, CMD_TERM_WR, CMD_TERM_RD, CMD_EDGE_WR,
      CMD_EDGE_RD, CMD_MODE_WR, CMD_MODE_RD, CMD_LEVEL_WR, CMD_LEVEL_RD,
      CMD_SLICE_RD, CMD_TC_WR, CMD_TC_RD, CMD_BAD_RD, CMD_FLAGS_RD,
      CMD_ENA_WR, CMD_ENA_RD, CMD_CLEAR, CMD_STORE, CMD_RECALL,
      CMD_POLL: ok = 1'b1;
      default:  ok = 1'b0;
    endcase
    return ok;
  endfunction

  // A write is acted on only when the command was taken, decoded cleanly
  // and its data were in bounds.
  function automatic logic doWrite(input cmd_code_type want);
    return take && !cmd.decodeErr && dataOk && (cmd.code == want);
  endfunction

  // ********************************************************************
  // Command acceptance and error classification
  // ********************************************************************

  // Recall needs a cycle for the memory read, so no command is taken then.
  assign cmdReady = !recallLoad_q;
  assign take     = cmd.valid && cmdReady;
  assign dataOk   = supported(cmd.code) && inBounds(cmd.code, cmd.data);
  assign cmdErr   = take && cmd.decodeErr;
  assign execErr  = take && !cmd.decodeErr && !dataOk;
  assign badInput = noSignal || clockOutOfRange;
  assign slot     = SLOT_W'(cmd.data - SLOT_FIRST);

  // ********************************************************************
  // Setup memory
  // ********************************************************************

  setup_memory #(
    .WIDTH (SET_W),
    .DEPTH (SETUP_SLOTS)
  ) uSetupMemory (
    .ref_clk (ref_clk),
    .rst     (rst),
    .wrEn    (doWrite(CMD_STORE)),
    .rdEn    (doWrite(CMD_RECALL)),
    .addr    (slot),
    .wrData  (settings_q),
    .rdData  (memRead)
  );

  // Marks the cycle in which recalled settings are loaded.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      recallLoad_q <= 1'b0;
    end else begin
      recallLoad_q <= doWrite(CMD_RECALL);
    end
  end

  // ********************************************************************
  // Settings
  // ********************************************************************

  // One process owns every setting; a rejected write never reaches it,
  // so the stored value stays as it was.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      settings_q.auxNibble   <= AUX_RESET;
      settings_q.term        <= TERM_50;
      settings_q.edgeSel     <= EDGE_POS;
      settings_q.balMode     <= BAL_AUTO;
      settings_q.offsetLevel <= LEVEL_RESET;
      settings_q.sliceLevel  <= LEVEL_RESET;
      settings_q.timeConst   <= TC_30MS;
    end else if (recallLoad_q) begin
      settings_q <= settings_type'(memRead);
    end else begin
      if (doWrite(CMD_AUX_WR)) begin
        settings_q.auxNibble <= cmd.data[3:0];
      end
      if (doWrite(CMD_TERM_WR)) begin
        settings_q.term <= term_type'(cmd.data[0]);
      end
      if (doWrite(CMD_EDGE_WR)) begin
        settings_q.edgeSel <= edge_type'(cmd.data[1:0]);
      end
      if (doWrite(CMD_MODE_WR)) begin
        settings_q.balMode <= bal_mode_type'(cmd.data[1:0]);
      end
      if (doWrite(CMD_TC_WR)) begin
        settings_q.timeConst <= time_const_type'(cmd.data[1:0]);
      end
      // Mode-steered level write; auto mode drops it.
      if (doWrite(CMD_LEVEL_WR)) begin
        case (settings_q.balMode)
          BAL_OFFSET: settings_q.offsetLevel <= cmd.data[11:0];
          BAL_MANUAL: settings_q.sliceLevel  <= cmd.data[11:0];
          default:    settings_q.offsetLevel <= settings_q.offsetLevel;
        endcase
      end else if (!remoteMode && panelLevelMoved) begin
        // Panel overrides level.
        // Only a panel move, a level write or a recall replaces it, so a remote value
        // survives the return to local control.
        case (settings_q.balMode)
          BAL_OFFSET: settings_q.offsetLevel <= panelLevel;
          BAL_MANUAL: settings_q.sliceLevel  <= panelLevel;
          default:    settings_q.offsetLevel <= settings_q.offsetLevel;
        endcase
      end
    end
  end

  assign settings        = settings_q;
  assign auxOutputNibble = settings_q.auxNibble;

  // ********************************************************************
  // Trigger edge on the signal input
  // ********************************************************************

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rfPrev_q <= 1'b0;
      rfTrig_q <= 1'b0;
    end else begin
      rfPrev_q <= rfIn;
      case (settings_q.edgeSel)
        EDGE_POS:    rfTrig_q <= rfIn && !rfPrev_q;
        EDGE_NEG:    rfTrig_q <= !rfIn && rfPrev_q;
        EDGE_EITHER: rfTrig_q <= rfIn ^ rfPrev_q;
        default:     rfTrig_q <= 1'b0;
      endcase
    end
  end

  assign rfTrig = rfTrig_q;

  // ********************************************************************
  // Event flags and enables
  // ********************************************************************

  // Only the used positions can ever be set.
  assign flagEvents = USED_FLAG_MASK & {2'b00,
                                        cmdErr,
                                        execErr,
                                        2'b00,
                                        badInput,
                                        inRange};

  // Level conditions are sampled each cycle.
  // Read or clear empties flags, but a same-cycle event still sets.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flags_q <= FLAGS_RESET;
    end else if (take && !cmd.decodeErr &&
                 (cmd.code == CMD_CLEAR || cmd.code == CMD_FLAGS_RD)) begin
      flags_q <= flagEvents;
    end else begin
      flags_q <= flags_q | flagEvents;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flagEna_q <= FLAGS_RESET;
    end else if (doWrite(CMD_ENA_WR)) begin
      flagEna_q <= cmd.data[7:0];
    end
  end

  // ********************************************************************
  // Status byte
  // ********************************************************************

  assign summary = |(flags_q & flagEna_q);

  // The service request latches on a rising summary so one event makes
  // one request, rather than re-raising while the summary stays high.
  // Poll clears the request; a new rise in that cycle wins.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      summaryPrev_q <= 1'b0;
      service_q     <= 1'b0;
    end else begin
      summaryPrev_q <= summary;
      if (summary && !summaryPrev_q) begin
        service_q <= 1'b1;
      end else if (take && !cmd.decodeErr && cmd.code == CMD_POLL) begin
        service_q <= 1'b0;
      end
    end
  end

  always_comb begin
    statusByte              = 8'h00;
    statusByte[SUMMARY_BIT] = summary;
    statusByte[SERVICE_BIT] = service_q;
  end

  // ********************************************************************
  // Query answers
  // ********************************************************************

  // Answers leave one cycle after the query as numeric codes; the
  // formatter adds the text, such as the hex marker on the nibble.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      resp_q <= '0;
    end else begin
      resp_q.valid <= 1'b0;
      resp_q.data  <= resp_q.data;
      if (take && !cmd.decodeErr) begin
        resp_q.valid <= 1'b1;
        case (cmd.code)
          CMD_AUX_RD:   resp_q.data <= {12'h000, settings_q.auxNibble};
          CMD_TERM_RD:  resp_q.data <= {15'h0000, settings_q.term};
          CMD_EDGE_RD:  resp_q.data <= {14'h0000, settings_q.edgeSel};
          CMD_MODE_RD:  resp_q.data <= {14'h0000, settings_q.balMode};
          CMD_LEVEL_RD: begin
            if (settings_q.balMode == BAL_MANUAL) begin
              resp_q.data <= {{4{settings_q.sliceLevel[11]}},
                              settings_q.sliceLevel};
            end else begin
              resp_q.data <= {{4{settings_q.offsetLevel[11]}},
                              settings_q.offsetLevel};
            end
          end
          CMD_SLICE_RD: resp_q.data <= {{4{sliceRef[11]}}, sliceRef};
          CMD_TC_RD:    resp_q.data <= {14'h0000, settings_q.timeConst};
          CMD_BAD_RD:   resp_q.data <= {15'h0000, badInput};
          CMD_FLAGS_RD: resp_q.data <= {8'h00, flags_q};
          CMD_ENA_RD:   resp_q.data <= {8'h00, flagEna_q};
          CMD_POLL:     resp_q.data <= {8'h00, statusByte};
          default:      resp_q.valid <= 1'b0;
        endcase
      end
    end
  end

  assign resp = resp_q;

endmodule

`default_nettype wire

// ===== bench/meter_remote_sva.sv
// Checker for the remote settings and event-status block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
`default_nettype none

module meter_remote_sva
  import meter_pkg::*;
(
  input wire logic         ref_clk,
  input wire logic         rst,
  input wire command_type  cmd,
  input wire logic         cmdReady,
  input wire response_type resp,
  input wire logic [11:0]  sliceRef,
  input wire logic [3:0]   auxOutputNibble,
  input wire settings_type settings,
  input wire logic [7:0]   statusByte
);
  // ****
  // Helpers
  // ****
  logic take;
  logic lvlOk;

  // A command counts only when taken and free of decode errors.
  assign take  = cmd.valid && cmdReady && !cmd.decodeErr;
  assign lvlOk = ($signed(cmd.data) >= LEVEL_MIN) &&
                 ($signed(cmd.data) <= LEVEL_MAX);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_aux_drive: assert property (
    take && cmd.code == CMD_AUX_WR && cmd.data <= AUX_MAX
    |=> auxOutputNibble == $past(cmd.data[3:0]))
    else $error("aux nibble not driven");
  chk_aux_reject: assert property (
    take && cmd.code == CMD_AUX_WR && cmd.data > AUX_MAX
    |=> $stable(auxOutputNibble))
    else $error("aux nibble changed on bad value");
  chk_slice_query: assert property (
    take && cmd.code == CMD_SLICE_RD |=> resp.valid &&
    resp.data == {{4{$past(sliceRef[11])}}, $past(sliceRef)})
    else $error("slice query wrong");
  chk_level_auto: assert property (
    take && cmd.code == CMD_LEVEL_WR && settings.balMode == BAL_AUTO
    |=> $stable(settings.offsetLevel) && $stable(settings.sliceLevel))
    else $error("level changed in automatic mode");
  chk_level_offset: assert property (
    take && cmd.code == CMD_LEVEL_WR && lvlOk &&
    settings.balMode == BAL_OFFSET
    |=> settings.offsetLevel == $past(cmd.data[11:0]))
    else $error("offset level not stored");
  chk_recall_stall: assert property (
    take && cmd.code == CMD_RECALL &&
    cmd.data >= SLOT_FIRST && cmd.data <= SLOT_LAST
    |=> !cmdReady ##1 cmdReady)
    else $error("recall stall wrong");
  chk_poll_clear: assert property (
    take && cmd.code == CMD_POLL && !$rose(statusByte[SUMMARY_BIT])
    |=> !statusByte[SERVICE_BIT])
    else $error("poll left request bit set");
  chk_service_rise: assert property (
    $rose(statusByte[SUMMARY_BIT]) |=> statusByte[SERVICE_BIT])
    else $error("request bit not raised");

  cover property (take && cmd.code == CMD_RECALL);
  cover property ($rose(statusByte[SERVICE_BIT]));
  cover property (take && cmd.code == CMD_LEVEL_WR &&
                  settings.balMode == BAL_MANUAL);
endmodule

`default_nettype wire

// ===== bench/ctrl_model.sv
// Bus controller model that issues one program message at a time.
// Assumes the command port contract: taken when valid and ready meet.
`timescale 1ns/1ns
`default_nettype none

module ctrl_model
  import meter_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire logic         cmdReady,
  input  wire response_type resp,
  output var  command_type  cmd
);
  logic [15:0] lastData;

  initial cmd = '{1'b0, CMD_NONE, 16'h0000, 1'b0};

  // Queries and clears use this cycle.
  // Idle data is inverted so a stale value is never mistaken for a live one.
  task automatic issue(input cmd_code_type code, input logic [15:0] data,
                       input logic err);
    @(posedge ref_clk);
    #1;
    cmd = '{1'b1, code, data, err};
    while (cmdReady !== 1'b1) begin
      @(posedge ref_clk);
      #1;
    end
    @(posedge ref_clk);
    #1;
    lastData = resp.valid ? resp.data : 16'hxxxx;
    cmd.valid = 1'b0;
    cmd.data = ~data;
  endtask
endmodule

`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench for the remote settings and event-status block.
// Assumes the controller model and the checker are compiled before it.
`timescale 1ns/1ns
`default_nettype none

module testbench;
  import meter_pkg::*;
  logic         ref_clk, rst, cmdReady, remoteMode, panelLevelMoved;
  logic         noSignal, clockOutOfRange, inRange, rfIn, rfTrig;
  logic [11:0]  panelLevel, sliceRef;
  logic [3:0]   auxOutputNibble;
  logic [7:0]   statusByte;
  logic [15:0]  v;
  command_type  cmd;
  response_type resp;
  settings_type settings;
  int           nFail, cmpCount;

  meter_remote_settings_status u_dut (.ref_clk(ref_clk), .rst(rst),
    .cmd(cmd), .cmdReady(cmdReady), .resp(resp), .remoteMode(remoteMode),
    .panelLevelMoved(panelLevelMoved), .panelLevel(panelLevel),
    .sliceRef(sliceRef), .noSignal(noSignal),
    .clockOutOfRange(clockOutOfRange), .inRange(inRange), .rfIn(rfIn),
    .rfTrig(rfTrig), .auxOutputNibble(auxOutputNibble),
    .settings(settings), .statusByte(statusByte));
  ctrl_model u_ctrl (.ref_clk(ref_clk), .cmdReady(cmdReady), .resp(resp),
    .cmd(cmd));

  // ****
  // Helpers
  // ****
  task automatic chk(input string n, input logic [15:0] got, exp);
    cmpCount++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", n, exp, got);
      nFail++;
    end
  endtask
  task automatic wr(input cmd_code_type c, input logic [15:0] d);
    u_ctrl.issue(c, d, 1'b0);
  endtask
  task automatic rd(input cmd_code_type c);
    u_ctrl.issue(c, 16'h0000, 1'b0);
    v = u_ctrl.lastData;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", cmpCount, nFail);
    if (nFail == 0 && cmpCount > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_aux();
    for (int i = 0; i < 16; i += 15) begin
      wr(CMD_AUX_WR, 16'(i));
      chk("aux pin", {12'h000, auxOutputNibble}, 16'(i));
      rd(CMD_AUX_RD);
      chk("aux query", v, 16'(i));
    end
    rd(CMD_FLAGS_RD);
    wr(CMD_AUX_WR, 16'h0010);
    chk("aux kept", {12'h000, auxOutputNibble}, 16'h000f);
    rd(CMD_FLAGS_RD);
    chk("range flag", v, 16'h0010);
  endtask
  task automatic t_sets();
    for (int i = 0; i < 4; i++) begin
      if (i < 2) begin
        wr(CMD_TERM_WR, 16'(i));
        rd(CMD_TERM_RD);
        chk("term", v, 16'(i));
      end
      if (i < 3) begin
        wr(CMD_EDGE_WR, 16'(i));
        rd(CMD_EDGE_RD);
        chk("edge", v, 16'(i));
      end
      wr(CMD_TC_WR, 16'(i));
      rd(CMD_TC_RD);
      chk("time const", v, 16'(i));
    end
  endtask
  task automatic t_level();
    wr(CMD_MODE_WR, 16'h0000);
    wr(CMD_LEVEL_WR, 16'h0123);
    chk("auto", {4'h0, settings.offsetLevel}, 16'h0000);
    wr(CMD_MODE_WR, 16'h0001);
    wr(CMD_LEVEL_WR, 16'hf800);
    rd(CMD_LEVEL_RD);
    chk("offset", v, 16'hf800);
    wr(CMD_MODE_WR, 16'h0002);
    wr(CMD_LEVEL_WR, 16'h07ff);
    rd(CMD_LEVEL_RD);
    chk("slice", v, 16'h07ff);
    chk("off kept", {4'h0, settings.offsetLevel}, 16'h0800);
    rd(CMD_FLAGS_RD);
    wr(CMD_LEVEL_WR, 16'h0800);
    chk("lvl kept", {4'h0, settings.sliceLevel}, 16'h07ff);
    rd(CMD_FLAGS_RD);
    chk("lvl flag", v, 16'h0010);
    rd(CMD_MODE_RD);
    chk("mode", v, 16'h0002);
  endtask
  task automatic t_panel();
    remoteMode = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk("local", {4'h0, settings.sliceLevel}, 16'h07ff);
    panelLevel = 12'h321;
    panelLevelMoved = 1'b1;
    @(posedge ref_clk);
    #1;
    panelLevelMoved = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("panel", {4'h0, settings.sliceLevel}, 16'h0321);
    remoteMode = 1'b1;
  endtask
  task automatic t_slice();
    sliceRef = 12'h9ab;
    for (int i = 0; i < 2; i++) begin
      wr(CMD_MODE_WR, 16'(i));
      rd(CMD_SLICE_RD);
      chk("slicer", v, 16'hf9ab);
    end
  endtask
  task automatic t_flags();
    rd(CMD_FLAGS_RD);
    wr(CMD_NONE, 16'h0000);
    rd(CMD_FLAGS_RD);
    chk("unsupported", v, 16'h0010);
    u_ctrl.issue(CMD_AUX_WR, 16'h0003, 1'b1);
    rd(CMD_FLAGS_RD);
    chk("decode", v, 16'h0020);
    rd(CMD_FLAGS_RD);
    chk("cleared", v, 16'h0000);
    noSignal = 1'b1;
    rd(CMD_BAD_RD);
    chk("bad", v, 16'h0001);
    noSignal = 1'b0;
    rd(CMD_BAD_RD);
    chk("good", v, 16'h0000);
    clockOutOfRange = 1'b1;
    inRange = 1'b1;
    rd(CMD_BAD_RD);
    chk("clock bad", v, 16'h0001);
    clockOutOfRange = 1'b0;
    inRange = 1'b0;
    rd(CMD_FLAGS_RD);
    chk("meas flags", v, 16'h0003);
    wr(CMD_ENA_WR, 16'h0020);
    rd(CMD_ENA_RD);
    chk("enable", v, 16'h0020);
    chk("sb idle", {8'h00, statusByte}, 16'h0000);
    u_ctrl.issue(CMD_TERM_WR, 16'h0000, 1'b1);
    @(posedge ref_clk);
    #1;
    chk("sb set", {8'h00, statusByte}, 16'h0060);
    rd(CMD_POLL);
    chk("poll", v, 16'h0060);
    chk("sb poll", {8'h00, statusByte}, 16'h0020);
    wr(CMD_CLEAR, 16'h0000);
    chk("sb clear", {8'h00, statusByte}, 16'h0000);
  endtask
  task automatic t_store();
    wr(CMD_AUX_WR, 16'h000a);
    wr(CMD_TERM_WR, 16'h0001);
    wr(CMD_STORE, 16'h0004);
    wr(CMD_AUX_WR, 16'h0003);
    wr(CMD_TERM_WR, 16'h0000);
    wr(CMD_RECALL, 16'h0004);
    @(posedge ref_clk);
    #1;
    chk("recall aux", {12'h000, auxOutputNibble}, 16'h000a);
    rd(CMD_TERM_RD);
    chk("recall term", v, 16'h0001);
  endtask
  // Pulse the signal input up then down under each edge selection.
  task automatic t_edge();
    for (int i = 0; i < 3; i++) begin
      wr(CMD_EDGE_WR, 16'(i));
      for (int j = 0; j < 2; j++) begin
        rfIn = ~rfIn;
        @(posedge ref_clk);
        #1;
        chk("trig", {15'h0000, rfTrig}, 16'((i == 2) || (i == j)));
      end
    end
  endtask

  // Free-running clock at 100 MHz.
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Cuts a hang short; the full run needs well under this span.
  initial begin
    #200000;
    nFail++;
    conclude();
  end

  // Reset, then run every scenario in turn.
  initial begin
    {rst, remoteMode} = 2'b11;
    {panelLevelMoved, noSignal, clockOutOfRange, inRange, rfIn} = 5'h00;
    panelLevel = 12'h000;
    sliceRef = 12'h000;
    nFail = 0;
    cmpCount = 0;
    repeat (4) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    t_aux();
    t_sets();
    t_level();
    t_panel();
    t_slice();
    t_flags();
    t_edge();
    t_store();
    conclude();
  end
endmodule

bind meter_remote_settings_status meter_remote_sva u_sva (
  .ref_clk(ref_clk), .rst(rst), .cmd(cmd), .cmdReady(cmdReady),
  .resp(resp), .sliceRef(sliceRef), .auxOutputNibble(auxOutputNibble),
  .settings(settings), .statusByte(statusByte));

`default_nettype wire
